// ===== common/remote_io_pkg.sv
`default_nettype none
package remote_io_pkg;
	// clock and serial timing
	localparam int CLK_HZ = 25_000_000;
	localparam int BAUD_RATE = 2400;
	localparam int BIT_CYCLES = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
	localparam int DATA_BITS = 8;
	localparam int REPORT_INTERVAL_S = 2;
	localparam int REPORT_CYCLES = CLK_HZ * REPORT_INTERVAL_S;
	localparam int DEBOUNCE_MS = 10;
	localparam int DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam int NUM_ALARMS = 2;
	localparam logic LINE_IDLE = 1'b1;
	localparam logic LINE_START = 1'b0;

	// dac codes, full code is 1 V or 20 mA
	localparam int DAC_W = 12;
	typedef logic [DAC_W-1:0] dac_t;
	localparam dac_t VOLT_RID_LOW = 12'h0400;
	localparam dac_t VOLT_RID_MED = 12'h0800;
	localparam dac_t VOLT_RID_HIGH = 12'h0c00;
	localparam dac_t VOLT_RID_AIR = 12'h0fff;
	localparam dac_t CURR_MIN = 12'h0333;
	localparam dac_t CURR_SPAN = 12'h0ccc;
	localparam dac_t CURR_RID_LOW = 12'h0666;
	localparam dac_t CURR_RID_MED = 12'h0999;
	localparam dac_t CURR_RID_HIGH = 12'h0ccc;
	localparam dac_t CURR_RID_AIR = 12'h0fff;

	// one-hot range relays
	localparam logic [3:0] RELAY_LOW = 4'h1;
	localparam logic [3:0] RELAY_MED = 4'h2;
	localparam logic [3:0] RELAY_HIGH = 4'h4;
	localparam logic [3:0] RELAY_AIR = 4'h8;

	typedef enum logic [1:0] {
		RANGE_LOW = 2'b00,
		RANGE_MED = 2'b01,
		RANGE_HIGH = 2'b10,
		RANGE_AIR = 2'b11
	} range_e;
	typedef enum logic [1:0] {
		CAL_IDLE = 2'b00,
		CAL_ZERO = 2'b01,
		CAL_SPAN = 2'b10
	} cal_state_e;
	typedef enum logic [1:0] {
		RPT_IDLE = 2'b00,
		RPT_LOAD = 2'b01,
		RPT_WAIT = 2'b10
	} rpt_state_e;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} rx_state_e;

	typedef struct packed {
		logic [15:0] threshold;
		logic high_acting;
		logic failsafe;
		logic latching;
		logic defeated;
	} alarm_cfg_s;
	typedef struct packed {
		dac_t pct_volt;
		dac_t rid_volt;
		dac_t pct_curr;
		dac_t rid_curr;
	} analog_out_s;

	// characters
	localparam logic [7:0] CHAR_CR = 8'h0d;
	localparam logic [7:0] CHAR_LF = 8'h0a;
	localparam logic [7:0] CHAR_A = 8'h61;
	localparam logic [7:0] CHAR_S = 8'h73;
	localparam logic [7:0] CHAR_Z = 8'h7a;
	localparam logic [7:0] CHAR_T = 8'h74;
	localparam logic [7:0] CHAR_DIGIT0 = 8'h30;
	localparam logic [7:0] CHAR_ONE = 8'h31;
	localparam logic [7:0] CHAR_HEX_OFS = 8'h37;
	localparam logic [7:0] CHAR_DASH = 8'h2d;

	// report items and their lengths including cr lf
	localparam logic [2:0] ITEM_CONC = 3'h0;
	localparam logic [2:0] ITEM_RANGE = 3'h1;
	localparam logic [2:0] ITEM_SPAN = 3'h2;
	localparam logic [2:0] ITEM_DIS1 = 3'h3;
	localparam logic [2:0] ITEM_DIS2 = 3'h4;
	localparam logic [2:0] ITEM_ON1 = 3'h5;
	localparam logic [3:0] LEN_CONC = 4'h6;
	localparam logic [3:0] LEN_RANGE2 = 4'h4;
	localparam logic [3:0] LEN_RANGE3 = 4'h5;
	localparam logic [3:0] LEN_SPAN = 4'h8;
	localparam logic [3:0] LEN_DIS = 4'hf;
	localparam logic [3:0] LEN_ON = 4'h9;
	localparam logic [3:0] TAG_DIGIT_POS = 4'h3;
	localparam logic [3:0] SPAN_HEX_POS = 4'h2;
	localparam logic [103:0] TXT_DIS = "AL-1 DISABLED";
	localparam logic [55:0] TXT_ON = "AL-1 ON";
	localparam logic [23:0] TXT_LO = "LO ";
	localparam logic [23:0] TXT_MED = "MED";
	localparam logic [23:0] TXT_HI = "HI ";
	localparam logic [23:0] TXT_AIR = "AIR";
endpackage
`default_nettype wire

// ===== src/uart_rx.sv
`default_nettype none
module uart_rx #(
	parameter int BIT_CYCLES = remote_io_pkg::BIT_CYCLES,
	parameter int DATA_BITS = remote_io_pkg::DATA_BITS
) (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// serial line
	input wire logic rxd,
	// received byte
	output logic [DATA_BITS-1:0] rx_data,
	output logic rx_valid
);
	import remote_io_pkg::*;

	localparam int CNT_W = $clog2(BIT_CYCLES);
	localparam int IDX_W = $clog2(DATA_BITS);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(BIT_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_HALF = CNT_W'(BIT_CYCLES / 2 - 1);
	localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(DATA_BITS - 1);

	rx_state_e state_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [IDX_W-1:0] idx_ff;
	logic [DATA_BITS-1:0] shift_ff;

	// 8n1 frame receiver, sampling mid-bit
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			state_ff <= RX_IDLE;
			cnt_ff <= '0;
			idx_ff <= '0;
			shift_ff <= '0;
			rx_data <= '0;
			rx_valid <= 1'b0;
		end
		else
		begin
			rx_valid <= 1'b0;
			cnt_ff <= cnt_ff + 1'b1;
			case (state_ff)
			RX_IDLE:
			begin
				cnt_ff <= '0;
				if (rxd == LINE_START)
					state_ff <= RX_START;
			end
			RX_START:
			begin
				if (cnt_ff == CNT_HALF)
				begin
					cnt_ff <= '0;
					idx_ff <= '0;
					state_ff <= (rxd == LINE_START) ? RX_DATA : RX_IDLE;
				end
			end
			RX_DATA:
			begin
				if (cnt_ff == CNT_LAST)
				begin
					cnt_ff <= '0;
					shift_ff <= {rxd, shift_ff[DATA_BITS-1:1]};
					idx_ff <= idx_ff + 1'b1;
					if (idx_ff == IDX_LAST)
						state_ff <= RX_STOP;
				end
			end
			RX_STOP:
			begin
				if (cnt_ff == CNT_LAST)
				begin
					state_ff <= RX_IDLE;
					if (rxd == LINE_IDLE)
					begin
						rx_data <= shift_ff;
						rx_valid <= 1'b1;
					end
				end
			end
			default:
				state_ff <= RX_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== src/analyzer_remote_io.sv
// Behaviour
// - voltage percent output follows concentration, zero to full code
// - voltage range id: quarter, half, three quarter, full code per range
// - current percent output spans minimum to maximum current code
// - current range id gives four ascending levels for the four ranges
// - each threshold alarm acts above or below its threshold
// - each alarm may be failsafe, latching, or defeated
// - system alarm sets on power fault or self test failure, always failsafe
// - system alarm clears only after power cycle and a non-system button
// - remote zero or span input starts that calibration
// - acknowledge contact closed exactly while calibration runs
// - remote inputs are polled while analysing with contact open
// - requests during calibration are ignored and not stored
// - input still held at calibration end restarts the same calibration
// - exactly one of four range relays closed for the active range
// - sample, zero and span valve outputs follow the operating mode
// - status report sent every interval while reporting is enabled
// - report: concentration, range, span, disabled, tripped; each ends cr lf
// - serial span or zero command with enter starts that calibration
// - serial toggle command with enter stops or resumes reports
// - serial link is 2400 baud, eight data bits, no parity, one stop
`default_nettype none
module analyzer_remote_io #(
	parameter int BAUD_DIV = remote_io_pkg::BIT_CYCLES,
	parameter int REPORT_PERIOD = remote_io_pkg::REPORT_CYCLES,
	parameter int DEBOUNCE_LEN = remote_io_pkg::DEBOUNCE_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// measurement
	input wire logic [15:0] conc_ppm,
	input wire remote_io_pkg::dac_t conc_frac,
	input wire remote_io_pkg::range_e active_range,
	input wire logic [15:0] range_full_scale,
	// threshold alarms
	input wire remote_io_pkg::alarm_cfg_s [remote_io_pkg::NUM_ALARMS-1:0] alarm_cfg,
	input wire logic alarm_reset,
	// supervision and front panel
	input wire logic power_fault,
	input wire logic selftest_fail,
	input wire logic power_cycled,
	input wire logic button_press,
	input wire logic system_button,
	// remote calibration
	input wire logic remote_zero_in,
	input wire logic remote_span_in,
	input wire logic cal_done,
	// serial port
	input wire logic serial_rxd,
	output logic serial_txd,
	output logic report_enabled,
	// analog outputs and relays
	output var remote_io_pkg::analog_out_s analog_out,
	output logic [3:0] range_relay,
	output logic [remote_io_pkg::NUM_ALARMS-1:0] alarm_relay,
	output logic system_alarm,
	output logic system_alarm_relay,
	// calibration handshake and valves
	output logic cal_contact,
	output logic sample_valve,
	output logic zero_valve,
	output logic span_valve
);
	import remote_io_pkg::*;

	localparam int RPT_W = $clog2(REPORT_PERIOD);
	localparam int BAUD_W = $clog2(BAUD_DIV);
	localparam int DB_W = $clog2(DEBOUNCE_LEN + 1);
	localparam int FRAME_BITS = DATA_BITS + 2;
	localparam logic [3:0] FRAME_LEN = 4'(FRAME_BITS);

	// analog outputs and range relays
	logic [2*DAC_W-1:0] curr_prod;
	dac_t nxt_rid_volt;
	dac_t nxt_rid_curr;
	logic [3:0] nxt_range_relay;

	assign curr_prod = conc_frac * CURR_SPAN;

	always_comb
	begin
		nxt_rid_volt = VOLT_RID_AIR;
		nxt_rid_curr = CURR_RID_AIR;
		nxt_range_relay = RELAY_AIR;
		case (active_range)
		RANGE_LOW:
		begin
			nxt_rid_volt = VOLT_RID_LOW;
			nxt_rid_curr = CURR_RID_LOW;
			nxt_range_relay = RELAY_LOW;
		end
		RANGE_MED:
		begin
			nxt_rid_volt = VOLT_RID_MED;
			nxt_rid_curr = CURR_RID_MED;
			nxt_range_relay = RELAY_MED;
		end
		RANGE_HIGH:
		begin
			nxt_rid_volt = VOLT_RID_HIGH;
			nxt_rid_curr = CURR_RID_HIGH;
			nxt_range_relay = RELAY_HIGH;
		end
		default:
		begin
			nxt_rid_volt = VOLT_RID_AIR;
			nxt_rid_curr = CURR_RID_AIR;
			nxt_range_relay = RELAY_AIR;
		end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			analog_out <= '0;
			range_relay <= '0;
		end
		else
		begin
			analog_out.pct_volt <= conc_frac;
			analog_out.pct_curr <= dac_t'(CURR_MIN + curr_prod[2*DAC_W-1:DAC_W]);
			analog_out.rid_volt <= nxt_rid_volt;
			analog_out.rid_curr <= nxt_rid_curr;
			range_relay <= nxt_range_relay;
		end
	end

	// threshold alarms; a set wins over reset
	logic [NUM_ALARMS-1:0] alarm_trip_ff;
	logic [NUM_ALARMS-1:0] alarm_hit;
	logic [NUM_ALARMS-1:0] nxt_alarm_trip;

	always_comb
	begin
		alarm_hit = '0;
		nxt_alarm_trip = '0;
		for (int k = 0; k < NUM_ALARMS; k++)
		begin
			alarm_hit[k] = alarm_cfg[k].high_acting ?
				(conc_ppm > alarm_cfg[k].threshold) :
				(conc_ppm < alarm_cfg[k].threshold);
			if (alarm_cfg[k].defeated)
				nxt_alarm_trip[k] = 1'b0;
			else if (alarm_cfg[k].latching)
				nxt_alarm_trip[k] = alarm_hit[k] |
					(alarm_trip_ff[k] & ~alarm_reset);
			else
				nxt_alarm_trip[k] = alarm_hit[k];
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			alarm_trip_ff <= '0;
			alarm_relay <= '0;
		end
		else
		begin
			alarm_trip_ff <= nxt_alarm_trip;
			for (int k = 0; k < NUM_ALARMS; k++)
				alarm_relay[k] <= alarm_cfg[k].failsafe ^ nxt_alarm_trip[k];
		end
	end

	// system alarm
	logic clear_armed_ff;
	logic sys_clear;
	logic nxt_system_alarm;

	assign sys_clear = clear_armed_ff & button_press & ~system_button;
	assign nxt_system_alarm = power_fault | selftest_fail |
		(system_alarm & ~sys_clear);

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			system_alarm <= 1'b0;
			system_alarm_relay <= 1'b0;
			clear_armed_ff <= 1'b0;
		end
		else
		begin
			system_alarm <= nxt_system_alarm;
			system_alarm_relay <= ~nxt_system_alarm;
			clear_armed_ff <= power_cycled | (clear_armed_ff & ~sys_clear);
		end
	end

	// remote input synchroniser and debounce, bit 0 zero, bit 1 span
	logic [1:0] cal_sync1_ff;
	logic [1:0] cal_sync2_ff;
	logic [1:0] cal_req_ff;
	logic [1:0][DB_W-1:0] db_cnt_ff;

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			cal_sync1_ff <= '0;
			cal_sync2_ff <= '0;
			cal_req_ff <= '0;
			db_cnt_ff <= '0;
		end
		else
		begin
			cal_sync1_ff <= {remote_span_in, remote_zero_in};
			cal_sync2_ff <= cal_sync1_ff;
			for (int k = 0; k < 2; k++)
			begin
				db_cnt_ff[k] <= '0;
				if (cal_sync2_ff[k] != cal_req_ff[k])
				begin
					if (db_cnt_ff[k] == DB_W'(DEBOUNCE_LEN - 1))
						cal_req_ff[k] <= cal_sync2_ff[k];
					else
						db_cnt_ff[k] <= db_cnt_ff[k] + 1'b1;
				end
			end
		end
	end

	// serial command parser
	logic [7:0] rx_data;
	logic rx_valid;
	logic [7:0] prev1_ff;
	logic [7:0] prev2_ff;
	logic cmd_zero_ff;
	logic cmd_span_ff;

	uart_rx #(
		.BIT_CYCLES(BAUD_DIV),
		.DATA_BITS(DATA_BITS)
	) u_rx (
		.clock(clock),
		.rstn(rstn),
		.rxd(serial_rxd),
		.rx_data(rx_data),
		.rx_valid(rx_valid)
	);

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			prev1_ff <= '0;
			prev2_ff <= '0;
			cmd_zero_ff <= 1'b0;
			cmd_span_ff <= 1'b0;
			report_enabled <= 1'b1;
		end
		else
		begin
			cmd_zero_ff <= 1'b0;
			cmd_span_ff <= 1'b0;
			if (rx_valid && rx_data == CHAR_CR)
			begin
				prev1_ff <= '0;
				prev2_ff <= '0;
				if ({prev2_ff, prev1_ff} == {CHAR_A, CHAR_Z})
					cmd_zero_ff <= 1'b1;
				if ({prev2_ff, prev1_ff} == {CHAR_A, CHAR_S})
					cmd_span_ff <= 1'b1;
				if ({prev2_ff, prev1_ff} == {CHAR_S, CHAR_T})
					report_enabled <= ~report_enabled;
			end
			else if (rx_valid)
			begin
				prev2_ff <= prev1_ff;
				prev1_ff <= rx_data;
			end
		end
	end

	// calibration handshake
	cal_state_e cal_state_ff;
	cal_state_e nxt_cal_state;

	always_comb
	begin
		nxt_cal_state = cal_state_ff;
		case (cal_state_ff)
		CAL_IDLE:
		begin
			if (cal_req_ff[0] || cmd_zero_ff)
				nxt_cal_state = CAL_ZERO;
			else if (cal_req_ff[1] || cmd_span_ff)
				nxt_cal_state = CAL_SPAN;
		end
		CAL_ZERO, CAL_SPAN:
		begin
			if (cal_done)
				nxt_cal_state = CAL_IDLE;
		end
		default:
			nxt_cal_state = CAL_IDLE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			cal_state_ff <= CAL_IDLE;
			cal_contact <= 1'b0;
			sample_valve <= 1'b1;
			zero_valve <= 1'b0;
			span_valve <= 1'b0;
		end
		else
		begin
			cal_state_ff <= nxt_cal_state;
			cal_contact <= nxt_cal_state != CAL_IDLE;
			sample_valve <= nxt_cal_state == CAL_IDLE;
			zero_valve <= nxt_cal_state == CAL_ZERO;
			span_valve <= nxt_cal_state == CAL_SPAN;
		end
	end

	// status report text
	function automatic logic [7:0] hex_char(input logic [3:0] n);
		return (n < 4'ha) ? CHAR_DIGIT0 + {4'h0, n} : CHAR_HEX_OFS + {4'h0, n};
	endfunction

	function automatic logic [3:0] item_len(input logic [2:0] item,
		input range_e rng);
		case (item)
		ITEM_CONC: return LEN_CONC;
		ITEM_RANGE: return (rng == RANGE_LOW || rng == RANGE_HIGH) ?
			LEN_RANGE2 : LEN_RANGE3;
		ITEM_SPAN: return LEN_SPAN;
		ITEM_DIS1, ITEM_DIS2: return LEN_DIS;
		default: return LEN_ON;
		endcase
	endfunction

	function automatic logic [7:0] item_char(input logic [2:0] item,
		input logic [3:0] pos, input logic [3:0] len,
		input logic [15:0] conc, input logic [15:0] span, input range_e rng);
		logic [15:0] nib;
		logic [23:0] rtxt;
		logic [103:0] dtxt;
		logic [55:0] otxt;
		logic [7:0] c;
		nib = (item == ITEM_CONC) ? conc << {pos, 2'b00} :
			span << {pos - SPAN_HEX_POS, 2'b00};
		case (rng)
		RANGE_LOW: rtxt = TXT_LO;
		RANGE_MED: rtxt = TXT_MED;
		RANGE_HIGH: rtxt = TXT_HI;
		default: rtxt = TXT_AIR;
		endcase
		rtxt = rtxt << {pos, 3'b000};
		dtxt = TXT_DIS << {pos, 3'b000};
		otxt = TXT_ON << {pos, 3'b000};
		c = otxt[55:48];
		if (pos == len - 4'h2)
			c = CHAR_CR;
		else if (pos == len - 4'h1)
			c = CHAR_LF;
		else if (item == ITEM_CONC)
			c = hex_char(nib[15:12]);
		else if (item == ITEM_RANGE)
			c = rtxt[23:16];
		else if (item == ITEM_SPAN)
			c = (pos == 4'h0) ? CHAR_DIGIT0 : (pos == 4'h1) ? CHAR_DASH :
				hex_char(nib[15:12]);
		else if (item == ITEM_DIS1 || item == ITEM_DIS2)
			c = (pos == TAG_DIGIT_POS) ? CHAR_ONE + 8'(item - ITEM_DIS1) :
				dtxt[103:96];
		else if (pos == TAG_DIGIT_POS)
			c = CHAR_ONE + 8'(item - ITEM_ON1);
		return c;
	endfunction

	function automatic logic [3:0] find_next(input logic [2:0] cur,
		input logic [7:0] mask);
		logic [3:0] r;
		r = '0;
		for (int k = 7; k >= 0; k--)
			if (k > int'(cur) && mask[k])
				r = {1'b1, 3'(k)};
		return r;
	endfunction

	// report sequencer and transmitter
	rpt_state_e rpt_state_ff;
	logic [RPT_W-1:0] rpt_timer_ff;
	logic [2:0] item_ff;
	logic [3:0] pos_ff;
	logic [15:0] snap_conc_ff;
	logic [15:0] snap_span_ff;
	range_e snap_range_ff;
	logic [7:0] snap_mask_ff;
	logic [FRAME_BITS-1:0] tx_shift_ff;
	logic [3:0] tx_bits_ff;
	logic [BAUD_W-1:0] baud_cnt_ff;
	logic rpt_tick;
	logic [3:0] cur_len;
	logic [7:0] cur_char;
	logic [3:0] nxt_item;

	assign rpt_tick = rpt_timer_ff == RPT_W'(REPORT_PERIOD - 1);
	assign cur_len = item_len(item_ff, snap_range_ff);
	assign cur_char = item_char(item_ff, pos_ff, cur_len, snap_conc_ff,
		snap_span_ff, snap_range_ff);
	assign nxt_item = find_next(item_ff, snap_mask_ff);

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			rpt_state_ff <= RPT_IDLE;
			rpt_timer_ff <= '0;
			item_ff <= ITEM_CONC;
			pos_ff <= '0;
			snap_conc_ff <= '0;
			snap_span_ff <= '0;
			snap_range_ff <= RANGE_LOW;
			snap_mask_ff <= '0;
		end
		else
		begin
			rpt_timer_ff <= rpt_tick ? '0 : rpt_timer_ff + 1'b1;
			case (rpt_state_ff)
			RPT_IDLE:
			begin
				if (rpt_tick && report_enabled)
				begin
					snap_conc_ff <= conc_ppm;
					snap_span_ff <= range_full_scale;
					snap_range_ff <= active_range;
					snap_mask_ff <= {system_alarm, alarm_trip_ff,
						alarm_cfg[1].defeated, alarm_cfg[0].defeated,
						3'b111};
					item_ff <= ITEM_CONC;
					pos_ff <= '0;
					rpt_state_ff <= RPT_LOAD;
				end
			end
			RPT_LOAD:
				rpt_state_ff <= RPT_WAIT;
			RPT_WAIT:
			begin
				if (tx_bits_ff == '0)
				begin
					rpt_state_ff <= RPT_LOAD;
					pos_ff <= pos_ff + 1'b1;
					if (pos_ff == cur_len - 4'h1)
					begin
						pos_ff <= '0;
						item_ff <= nxt_item[2:0];
						if (!nxt_item[3])
							rpt_state_ff <= RPT_IDLE;
					end
				end
			end
			default:
				rpt_state_ff <= RPT_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			tx_shift_ff <= '1;
			tx_bits_ff <= '0;
			baud_cnt_ff <= '0;
			serial_txd <= LINE_IDLE;
		end
		else
		begin
			serial_txd <= tx_shift_ff[0];
			if (rpt_state_ff == RPT_LOAD)
			begin
				tx_shift_ff <= {LINE_IDLE, cur_char, LINE_START};
				tx_bits_ff <= FRAME_LEN;
				baud_cnt_ff <= '0;
			end
			else if (tx_bits_ff != '0)
			begin
				baud_cnt_ff <= baud_cnt_ff + 1'b1;
				if (baud_cnt_ff == BAUD_W'(BAUD_DIV - 1))
				begin
					baud_cnt_ff <= '0;
					tx_shift_ff <= {LINE_IDLE, tx_shift_ff[FRAME_BITS-1:1]};
					tx_bits_ff <= tx_bits_ff - 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb/remote_io_chk.sv
`default_nettype none
module remote_io_chk (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// inputs watched
	input wire remote_io_pkg::dac_t conc_frac,
	input wire remote_io_pkg::range_e active_range,
	input wire remote_io_pkg::alarm_cfg_s [remote_io_pkg::NUM_ALARMS-1:0] alarm_cfg,
	input wire logic power_fault,
	input wire logic selftest_fail,
	input wire logic button_press,
	input wire logic remote_zero_in,
	input wire logic cal_done,
	// outputs watched
	input wire remote_io_pkg::analog_out_s analog_out,
	input wire logic [3:0] range_relay,
	input wire logic [remote_io_pkg::NUM_ALARMS-1:0] alarm_relay,
	input wire logic system_alarm,
	input wire logic cal_contact,
	input wire logic sample_valve,
	input wire logic zero_valve,
	input wire logic span_valve
);
	import remote_io_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	sequence s_zero_held;
		remote_zero_in [*8] ##0 (cal_done && zero_valve);
	endsequence
	sequence s_reclose;
		!cal_contact ##1 (cal_contact && zero_valve);
	endsequence
	chk_relay_onehot: assert property (
		$past(rstn, 2) |-> range_relay == 4'h1 << $past(active_range))
		else $error("range relay mismatch");
	chk_pct_volt: assert property (
		$past(rstn, 2) |-> analog_out.pct_volt == $past(conc_frac))
		else $error("voltage percent mismatch");
	chk_rid_volt: assert property (
		$past(rstn, 2) |-> analog_out.rid_volt ==
		($past(active_range) == RANGE_AIR ? VOLT_RID_AIR :
		{$past(active_range) + 2'h1, 10'h000}))
		else $error("voltage range id mismatch");
	chk_pct_curr: assert property (
		$past(rstn, 2) |-> analog_out.pct_curr == CURR_MIN +
		dac_t'(({12'h000, $past(conc_frac)} * CURR_SPAN) >> 12))
		else $error("current percent mismatch");
	chk_rid_curr: assert property (
		$past(rstn, 2) |-> analog_out.rid_curr ==
		dac_t'(CURR_MIN * (12'h002 + $past(active_range))))
		else $error("current range id mismatch");
	chk_valve_mode: assert property (
		cal_contact == (zero_valve || span_valve) &&
		sample_valve == !cal_contact && !(zero_valve && span_valve))
		else $error("valves disagree with contact");
	chk_cal_release: assert property (
		cal_contact && cal_done |=> !cal_contact)
		else $error("contact stayed closed after done");
	chk_cal_ignore: assert property (
		cal_contact && !cal_done |=> cal_contact && $stable(zero_valve))
		else $error("calibration changed while running");
	chk_cal_restart: assert property (
		s_zero_held |=> s_reclose)
		else $error("held request did not restart");
	chk_sys_set: assert property (
		power_fault || selftest_fail |=> system_alarm)
		else $error("system alarm not set");
	chk_sys_latch: assert property (
		system_alarm && !button_press |=> system_alarm)
		else $error("system alarm cleared without button");
	chk_alarm_defeat: assert property (
		$past(rstn, 2) && $past(alarm_cfg[0].defeated) |->
		alarm_relay[0] == $past(alarm_cfg[0].failsafe))
		else $error("defeated alarm actuated");
endmodule
bind analyzer_remote_io remote_io_chk u_chk (.clock, .rstn, .conc_frac,
	.active_range, .alarm_cfg, .power_fault, .selftest_fail, .button_press,
	.remote_zero_in, .cal_done, .analog_out, .range_relay, .alarm_relay,
	.system_alarm, .cal_contact, .sample_valve, .zero_valve, .span_valve);
`default_nettype wire

// ===== tb/remote_ctrl_model.sv
`default_nettype none
module remote_ctrl_model #(
	parameter int BAUD_DIV = 16
) (
	// clock and watched lines
	input wire logic clock,
	input wire logic cal_contact,
	input wire logic serial_txd,
	// requests
	output logic remote_zero_in,
	output logic remote_span_in,
	output logic serial_rxd
);
	logic [7:0] rxq[$];
	logic [7:0] rb;
	initial
	begin
		remote_zero_in = 1'b0;
		remote_span_in = 1'b0;
		serial_rxd = 1'b1;
	end
	// hold 0 keeps the handshake, otherwise holds blindly
	task automatic req(input logic sp, input int hold, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		@(posedge clock);
		if (hold == 0 && cal_contact !== 1'b0)
			return;
		remote_zero_in <= !sp;
		remote_span_in <= sp;
		while (hold == 0 ? cal_contact !== 1'b1 && n < 200 : n < hold)
		begin
			@(posedge clock);
			n++;
		end
		remote_zero_in <= 1'b0;
		remote_span_in <= 1'b0;
		@(posedge clock);
		ok = cal_contact;
	endtask
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		@(posedge clock);
		for (int i = 0; i < 10; i++)
		begin
			serial_rxd <= f[i];
			repeat (BAUD_DIV) @(posedge clock);
		end
	endtask
	initial
	forever
	begin
		@(negedge serial_txd);
		repeat (BAUD_DIV / 2) @(posedge clock);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BAUD_DIV) @(posedge clock);
			rb[i] = serial_txd;
		end
		repeat (BAUD_DIV) @(posedge clock);
		if (serial_txd === 1'b1)
			rxq.push_back(rb);
	end
endmodule
`default_nettype wire

// ===== tb/tb_analyzer_remote_io.sv
`default_nettype none
module tb_analyzer_remote_io;
	timeunit 1ns;
	timeprecision 1ns;
	import remote_io_pkg::*;
	logic clock, rstn, alarm_reset, power_fault, selftest_fail, ok;
	logic power_cycled, button_press, system_button, cal_done;
	logic [15:0] conc_ppm, range_full_scale;
	dac_t conc_frac;
	range_e active_range;
	alarm_cfg_s [NUM_ALARMS-1:0] alarm_cfg;
	wire logic remote_zero_in, remote_span_in, serial_rxd;
	logic serial_txd, report_enabled, system_alarm, system_alarm_relay;
	logic cal_contact, sample_valve, zero_valve, span_valve;
	logic [3:0] range_relay;
	logic [NUM_ALARMS-1:0] alarm_relay;
	analog_out_s analog_out;
	int fails = 0, tests_run = 0, cyc = 0;
	analyzer_remote_io #(.BAUD_DIV(16), .REPORT_PERIOD(4000),
		.DEBOUNCE_LEN(4)) DUT (.clock, .rstn, .conc_ppm, .conc_frac,
		.active_range, .range_full_scale, .alarm_cfg, .alarm_reset,
		.power_fault, .selftest_fail, .power_cycled, .button_press,
		.system_button, .remote_zero_in, .remote_span_in, .cal_done,
		.serial_rxd, .serial_txd, .report_enabled, .analog_out,
		.range_relay, .alarm_relay, .system_alarm, .system_alarm_relay,
		.cal_contact, .sample_valve, .zero_valve, .span_valve);
	remote_ctrl_model #(.BAUD_DIV(16)) P (.clock, .cal_contact,
		.serial_txd, .remote_zero_in, .remote_span_in, .serial_rxd);
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task automatic finish_test();
		if (fails == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			fails++;
			finish_test();
		end
	end
	task automatic chk(input string n, input logic [15:0] e, g);
		tests_run++;
		if (g !== e)
		begin
			fails++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic look();
		@(negedge clock);
	endtask
	task automatic done();
		tick(8);
		cal_done <= 1'b1;
		tick(1);
		cal_done <= 1'b0;
	endtask
	task automatic t_analog();
		dac_t vr[4] = '{VOLT_RID_LOW, VOLT_RID_MED, VOLT_RID_HIGH, VOLT_RID_AIR};
		dac_t cr[4] = '{CURR_RID_LOW, CURR_RID_MED, CURR_RID_HIGH, CURR_RID_AIR};
		dac_t f;
		for (int r = 0; r < 4; r++)
		begin
			f = dac_t'(r * 12'h0555);
			tick(1);
			active_range <= range_e'(r);
			conc_frac <= f;
			tick(3);
			look();
			chk("range_relay", 16'(4'h1 << r), 16'(range_relay));
			chk("pct_volt", 16'(f), 16'(analog_out.pct_volt));
			chk("pct_curr", 16'(CURR_MIN + 12'((24'(f) * CURR_SPAN) >> 12)),
				16'(analog_out.pct_curr));
			chk("rid_volt", 16'(vr[r]), 16'(analog_out.rid_volt));
			chk("rid_curr", 16'(cr[r]), 16'(analog_out.rid_curr));
		end
	endtask
	task automatic alm(input logic [3:0] m, input logic [15:0] c, input logic e);
		tick(1);
		alarm_cfg <= {2{16'h0064, m}};
		conc_ppm <= c;
		tick(3);
		look();
		chk("alarm_relay", 16'({2{e}}), 16'(alarm_relay));
	endtask
	task automatic t_alarm();
		alm(4'b1000, 16'h00c8, 1'b1);
		alm(4'b1000, 16'h0032, 1'b0);
		alm(4'b0000, 16'h0032, 1'b1);
		alm(4'b0100, 16'h0032, 1'b0);
		alm(4'b0100, 16'h00c8, 1'b1);
		alm(4'b1001, 16'h00c8, 1'b0);
		alm(4'b1010, 16'h00c8, 1'b1);
		alm(4'b1010, 16'h0032, 1'b1);
		alarm_reset <= 1'b1;
		alm(4'b1010, 16'h0032, 1'b0);
		alarm_reset <= 1'b0;
		alarm_cfg <= {2{16'hffff, 4'b1000}};
		conc_ppm <= 16'h1a2b;
	endtask
	task automatic ev(input logic [4:0] v, input logic e);
		tick(1);
		{power_fault, selftest_fail, power_cycled, button_press,
			system_button} <= v;
		tick(1);
		{power_fault, selftest_fail, power_cycled, button_press,
			system_button} <= 5'h00;
		tick(2);
		look();
		chk("system_alarm", 16'(e), 16'(system_alarm));
		chk("system_relay", 16'(!e), 16'(system_alarm_relay));
	endtask
	task automatic t_sys();
		ev(5'h10, 1'b1);
		ev(5'h02, 1'b1);
		ev(5'h04, 1'b1);
		ev(5'h03, 1'b1);
		ev(5'h02, 1'b0);
		ev(5'h08, 1'b1);
		ev(5'h04, 1'b1);
		ev(5'h02, 1'b0);
	endtask
	task automatic t_remote();
		P.req(1'b0, 2, ok);
		tick(15);
		look();
		chk("glitch_contact", 16'h0000, 16'(cal_contact));
		P.req(1'b0, 0, ok);
		chk("zero_ack", 16'h0001, 16'(ok));
		look();
		chk("zero_valve", 16'h0001, 16'(zero_valve));
		chk("sample_valve", 16'h0000, 16'(sample_valve));
		P.req(1'b1, 20, ok);
		done();
		tick(15);
		look();
		chk("ignored_contact", 16'h0000, 16'(cal_contact));
		P.req(1'b1, 0, ok);
		look();
		chk("span_valve", 16'h0001, 16'(span_valve));
		done();
		fork
			P.req(1'b0, 40, ok);
			begin
				tick(20);
				done();
			end
		join
		look();
		chk("restart_contact", 16'h0001, 16'(cal_contact));
		done();
		tick(15);
		look();
		chk("final_contact", 16'h0000, 16'(cal_contact));
	endtask
	task automatic cmd(input logic [15:0] c);
		P.send_byte(c[15:8]);
		P.send_byte(c[7:0]);
		P.send_byte(CHAR_CR);
		tick(4);
		look();
	endtask
	task automatic t_serial();
		string ex = "1A2B\r\nMED\r\n0-0100\r\n";
		tick(1);
		active_range <= RANGE_MED;
		cmd("az");
		chk("az_zero", 16'h0001, 16'(zero_valve));
		done();
		cmd("as");
		chk("as_span", 16'h0001, 16'(span_valve));
		done();
		cmd("xz");
		chk("junk_contact", 16'h0000, 16'(cal_contact));
		chk("junk_report", 16'h0001, 16'(report_enabled));
		cmd("st");
		chk("st_off", 16'h0000, 16'(report_enabled));
		tick(4000);
		P.rxq.delete();
		tick(4000);
		chk("quiet", 16'h0000, 16'(P.rxq.size()));
		cmd("st");
		chk("st_on", 16'h0001, 16'(report_enabled));
		for (int n = 0; n < 12000 && P.rxq.size() < 38; n++)
			tick(1);
		chk("report_len", 16'd38, 16'(P.rxq.size()));
		for (int i = 0; i < 38 && i < P.rxq.size(); i++)
			chk("report_byte", 16'(ex[i % 19]), 16'(P.rxq[i]));
	endtask
	initial
	begin
		rstn = 1'b0;
		{alarm_reset, power_fault, selftest_fail, cal_done} = 4'h0;
		{power_cycled, button_press, system_button} = 3'h0;
		conc_ppm = 16'h0000;
		range_full_scale = 16'h0100;
		conc_frac = 12'h000;
		active_range = RANGE_LOW;
		alarm_cfg = '0;
		tick(3);
		rstn <= 1'b1;
		tick(2);
		t_analog();
		t_alarm();
		t_sys();
		t_remote();
		t_serial();
		finish_test();
	end
endmodule
`default_nettype wire
